// ===== core/smp_mode_ctrl.sv
// Operating-mode controller and host mailbox of the light and proximity sensor
`timescale 1ns/1ps
`default_nettype none
module smp_mode_ctrl (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        SECOND_EMITTER_DRIVE_PIN,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_RD,
    input  wire logic [5:0]  HOST_ADDR,
    input  wire logic [7:0]  HOST_WDATA,
    output logic      [7:0]  HOST_RDATA,
    input  wire logic        BUS_ADDR_VALID,
    input  wire logic [6:0]  BUS_ADDR,
    input  wire logic        BUS_ADDR_TEN,
    output logic             BUS_ADDR_ACK,
    input  wire logic [15:0] PS_SAMPLE,
    input  wire logic [15:0] ALS_SAMPLE,
    output logic             MEAS_ACTIVE,
    output logic      [2:0]  MODE,
    output logic             INT_O,
    output logic             INT_OE
);

    typedef struct packed {
        smp_pkg::smp_mode_t mode;
        logic               strap_meta;
        logic               strap_sync;
        logic [6:0]         dev_addr;
        logic [3:0]         irq_status;
        logic [3:0]         irq_enable;
        logic               int_drive;
        logic [15:0]        ps_res;
        logic [15:0]        als_res;
        logic [7:0]         param_in;
        logic [7:0]         response1;
        logic [3:0]         cmd_count;
        logic               cmd_error;
        logic [7:0]         rdata;
        logic [11:0]        init_cnt;
        logic               conv_busy;
        logic [11:0]        conv_cnt;
        logic [11:0]        tick_cnt;
        logic [15:0]        rate_cnt;
    } smp_state_t;

    localparam smp_state_t RESET_STATE = '{
        mode:       smp_pkg::MODE_OFF,
        strap_meta: 1'b0,
        strap_sync: 1'b0,
        dev_addr:   smp_pkg::ADDR_ALTERNATE,
        irq_status: 4'h0,
        irq_enable: 4'h0,
        int_drive:  1'b0,
        ps_res:     16'h0000,
        als_res:    16'h0000,
        param_in:   8'h00,
        response1:  8'h00,
        cmd_count:  smp_pkg::CMD_COUNT_RESET,
        cmd_error:  1'b0,
        rdata:      8'h00,
        init_cnt:   12'h000,
        conv_busy:  1'b0,
        conv_cnt:   12'h000,
        tick_cnt:   12'h000,
        rate_cnt:   16'h0000
    };

    smp_state_t s;
    smp_state_t next_s;

    logic        param_clear;
    logic        param_we;
    logic [5:0]  param_waddr;
    logic [7:0]  param_wdata;
    logic [5:0]  param_raddr;
    logic [7:0]  param_rdata;
    logic [7:0]  chan_list;
    logic [15:0] meas_rate;
    logic [15:0] ps_thr;
    logic [15:0] als_thr;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter storage

    smp_param_table u_table (
        .clk       (CLK_SYS),
        .rstn      (RSTN),
        .clear     (param_clear),
        .we        (param_we),
        .waddr     (param_waddr),
        .wdata     (param_wdata),
        .raddr     (param_raddr),
        .rdata     (param_rdata),
        .chan_list (chan_list),
        .meas_rate (meas_rate),
        .ps_thr    (ps_thr),
        .als_thr   (als_thr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    function automatic logic [7:0] read_mux(input smp_state_t st, input logic [5:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == smp_pkg::REG_IRQ_STATUS) begin
            d = {4'h0, st.irq_status};
        end else if (a == smp_pkg::REG_PS_H) begin
            d = st.ps_res[15:8];
        end else if (a == smp_pkg::REG_PS_L) begin
            d = st.ps_res[7:0];
        end else if (a == smp_pkg::REG_ALS_H) begin
            d = st.als_res[15:8];
        end else if (a == smp_pkg::REG_ALS_L) begin
            d = st.als_res[7:0];
        end else if (a == smp_pkg::REG_IRQ_ENABLE) begin
            d = {4'h0, st.irq_enable};
        end else if (a == smp_pkg::REG_PARAM_IN) begin
            d = st.param_in;
        end else if (a == smp_pkg::REG_RESPONSE1) begin
            d = st.response1;
        end else if (a == smp_pkg::REG_CMD_RESP) begin
            d = {3'h0, st.cmd_error, st.cmd_count};
        end else if (a == smp_pkg::REG_DEV_ADDR) begin
            d = {1'b0, st.dev_addr};
        end
        return d;
    endfunction

    always_comb begin
        logic        host_ok;
        logic        conv_done;
        logic        tick;
        logic        soft_reset;
        logic        cmd_done;
        logic        cmd_bad;
        logic [3:0]  irq_set;
        logic [3:0]  irq_clr;
        logic [7:0]  cmd;
        host_ok     = 1'b0;
        conv_done   = 1'b0;
        tick        = 1'b0;
        soft_reset  = 1'b0;
        cmd_done    = 1'b0;
        cmd_bad     = 1'b0;
        irq_set     = 4'h0;
        irq_clr     = 4'h0;
        cmd         = HOST_WDATA;
        next_s      = s;
        param_clear = 1'b0;
        param_we    = 1'b0;
        param_waddr = cmd[5:0];
        param_wdata = s.param_in;
        param_raddr = cmd[5:0];

        // Strap pin crosses in through two flops
        next_s.strap_meta = SECOND_EMITTER_DRIVE_PIN;
        next_s.strap_sync = s.strap_meta;

        case (s.mode)
            smp_pkg::MODE_OFF: begin
                next_s.mode     = smp_pkg::MODE_INIT;
                next_s.init_cnt = 12'h000;
            end
            smp_pkg::MODE_INIT: begin
                next_s.init_cnt = s.init_cnt + 12'h001;
                if (s.init_cnt == 12'(smp_pkg::INIT_CYC - 1)) begin
                    next_s.dev_addr = s.strap_sync ? smp_pkg::ADDR_PRIMARY
                                                   : smp_pkg::ADDR_ALTERNATE;
                    next_s.mode     = smp_pkg::MODE_STANDBY;
                end
            end
            default: begin
                host_ok = 1'b1;
            end
        endcase

        // Autonomous rate: tick divider then period count
        if (s.mode == smp_pkg::MODE_AUTO) begin
            tick = (s.tick_cnt == 12'(smp_pkg::RATE_TICK_CYC - 1));
            next_s.tick_cnt = tick ? 12'h000 : s.tick_cnt + 12'h001;
            if (tick && !s.conv_busy) begin
                if (s.rate_cnt >= meas_rate) begin
                    next_s.rate_cnt  = 16'h0000;
                    next_s.conv_busy = 1'b1;
                    next_s.conv_cnt  = 12'h000;
                end else begin
                    next_s.rate_cnt = s.rate_cnt + 16'h0001;
                end
            end
        end

        // Conversion timer and result capture
        if (s.conv_busy) begin
            next_s.conv_cnt = s.conv_cnt + 12'h001;
            conv_done = (s.conv_cnt == 12'(smp_pkg::CONV_CYC - 1));
        end
        if (conv_done) begin
            next_s.conv_busy = 1'b0;
            if (chan_list[smp_pkg::CHAN_PS_BIT]) begin
                next_s.ps_res                 = PS_SAMPLE;
                irq_set[smp_pkg::IRQ_PS_DONE] = 1'b1;
                irq_set[smp_pkg::IRQ_PS_THR]  = (PS_SAMPLE >= ps_thr);
            end
            if (chan_list[smp_pkg::CHAN_ALS_BIT]) begin
                next_s.als_res                 = ALS_SAMPLE;
                irq_set[smp_pkg::IRQ_ALS_DONE] = 1'b1;
                irq_set[smp_pkg::IRQ_ALS_THR]  = (ALS_SAMPLE >= als_thr);
            end
            if (s.mode == smp_pkg::MODE_FORCED) begin
                next_s.mode = smp_pkg::MODE_STANDBY;
            end
        end

        // Host reads only capture data, leaving the sequencer asleep
        if (host_ok && HOST_RD) begin
            next_s.rdata = read_mux(s, HOST_ADDR);
        end

        // Host writes into the mailbox
        if (host_ok && HOST_WR) begin
            if (HOST_ADDR == smp_pkg::REG_IRQ_STATUS) begin
                irq_clr = HOST_WDATA[3:0];
            end else if (HOST_ADDR == smp_pkg::REG_IRQ_ENABLE) begin
                next_s.irq_enable = HOST_WDATA[3:0];
            end else if (HOST_ADDR == smp_pkg::REG_PARAM_IN) begin
                next_s.param_in = HOST_WDATA;
            end else if (HOST_ADDR == smp_pkg::REG_DEV_ADDR) begin
                next_s.dev_addr = HOST_WDATA[6:0];
            end else if (HOST_ADDR == smp_pkg::REG_COMMAND) begin
                if (cmd == smp_pkg::CMD_COUNTER_CLEAR) begin
                    next_s.cmd_count = 4'h0;
                    next_s.cmd_error = 1'b0;
                end else if (cmd == smp_pkg::CMD_SOFT_RESET) begin
                    soft_reset = 1'b1;
                end else if (cmd[7:6] == smp_pkg::CMD_PARAM_READ) begin
                    if (cmd[5:0] < 6'(smp_pkg::PARAM_DEPTH)) begin
                        next_s.response1 = param_rdata;
                        cmd_done         = 1'b1;
                    end else begin
                        cmd_bad = 1'b1;
                    end
                end else if (cmd[7:6] == smp_pkg::CMD_PARAM_WRITE) begin
                    if (cmd[5:0] < 6'(smp_pkg::PARAM_DEPTH)) begin
                        param_we         = 1'b1;
                        next_s.response1 = s.param_in;
                        cmd_done         = 1'b1;
                    end else begin
                        cmd_bad = 1'b1;
                    end
                end else if (cmd == smp_pkg::CMD_FORCE) begin
                    cmd_done = 1'b1;
                    if (s.mode == smp_pkg::MODE_STANDBY) begin
                        next_s.mode      = smp_pkg::MODE_FORCED;
                        next_s.conv_busy = 1'b1;
                        next_s.conv_cnt  = 12'h000;
                    end
                end else if (cmd == smp_pkg::CMD_START) begin
                    cmd_done = 1'b1;
                    if (s.mode == smp_pkg::MODE_STANDBY) begin
                        next_s.mode     = smp_pkg::MODE_AUTO;
                        next_s.rate_cnt = 16'h0000;
                        next_s.tick_cnt = 12'h000;
                    end
                end else if (cmd == smp_pkg::CMD_PAUSE) begin
                    cmd_done = 1'b1;
                    if (s.mode == smp_pkg::MODE_AUTO) begin
                        // An in-flight autonomous conversion is dropped
                        next_s.mode      = smp_pkg::MODE_STANDBY;
                        next_s.conv_busy = 1'b0;
                    end
                end else begin
                    cmd_bad = 1'b1;
                end
            end
        end

        // Errors freeze the count until the host clears them
        if (cmd_bad) begin
            next_s.cmd_error = 1'b1;
        end else if (cmd_done && !s.cmd_error) begin
            next_s.cmd_count = s.cmd_count + 4'h1;
        end

        // Hardware set wins over a host clear in the same cycle
        next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
        next_s.int_drive  = |(next_s.irq_status & next_s.irq_enable);

        if (soft_reset) begin
            next_s      = RESET_STATE;
            param_clear = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Target address match; no answer until initialization is over
    assign BUS_ADDR_ACK = BUS_ADDR_VALID && !BUS_ADDR_TEN
                          && (BUS_ADDR == s.dev_addr)
                          && (s.mode != smp_pkg::MODE_OFF)
                          && (s.mode != smp_pkg::MODE_INIT);
    assign HOST_RDATA   = s.rdata;
    assign MEAS_ACTIVE  = s.conv_busy;
    assign MODE         = s.mode;
    assign INT_O        = 1'b0;
    assign INT_OE       = s.int_drive;

endmodule
`default_nettype wire

// ===== core/smp_param_table.sv
// Volatile parameter table owned by the internal controller
`timescale 1ns/1ps
`default_nettype none
module smp_param_table (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clear,
    input  wire logic        we,
    input  wire logic [5:0]  waddr,
    input  wire logic [7:0]  wdata,
    input  wire logic [5:0]  raddr,
    output logic      [7:0]  rdata,
    output logic      [7:0]  chan_list,
    output logic      [15:0] meas_rate,
    output logic      [15:0] ps_thr,
    output logic      [15:0] als_thr
);

    typedef struct packed {
        logic [smp_pkg::PARAM_DEPTH-1:0][7:0] mem;
    } smp_tbl_state_t;

    smp_tbl_state_t s;
    smp_tbl_state_t next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < smp_pkg::PARAM_DEPTH; i++) begin
            if (clear) begin
                next_s.mem[i] = smp_pkg::PARAM_RESET;
            end else if (we && waddr == 6'(i)) begin
                next_s.mem[i] = wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Out-of-range reads return zero; the caller flags them as errors
    assign rdata     = (raddr < 6'(smp_pkg::PARAM_DEPTH)) ? s.mem[raddr] : 8'h00;
    assign chan_list = s.mem[smp_pkg::PAR_CHAN_LIST];
    assign meas_rate = {s.mem[smp_pkg::PAR_RATE_H], s.mem[smp_pkg::PAR_RATE_L]};
    assign ps_thr    = {s.mem[smp_pkg::PAR_PS_THR_H], s.mem[smp_pkg::PAR_PS_THR_L]};
    assign als_thr   = {s.mem[smp_pkg::PAR_ALS_THR_H], s.mem[smp_pkg::PAR_ALS_THR_L]};

endmodule
`default_nettype wire

// ===== core/smp_pkg.sv
// Constants and types shared by the sensor mode controller and its parameter table
package smp_pkg;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_INIT,
        MODE_STANDBY,
        MODE_FORCED,
        MODE_AUTO
    } smp_mode_t;

    // Clock and timing
    localparam int CLK_MHZ          = 20;
    localparam int INIT_TIME_US     = 25;
    localparam int INIT_CYC         = INIT_TIME_US * CLK_MHZ;
    localparam int CONV_TIME_US     = 155;
    localparam int CONV_CYC         = CONV_TIME_US * CLK_MHZ;
    localparam int RATE_TICK_US     = 100;
    localparam int RATE_TICK_CYC    = RATE_TICK_US * CLK_MHZ;

    // Serial target addresses
    localparam logic [6:0] ADDR_PRIMARY   = 7'h53;
    localparam logic [6:0] ADDR_ALTERNATE = 7'h52;

    // Mailbox register offsets, status first then outputs for burst reads
    localparam logic [5:0] REG_IRQ_STATUS = 6'h00;
    localparam logic [5:0] REG_PS_H       = 6'h01;
    localparam logic [5:0] REG_PS_L       = 6'h02;
    localparam logic [5:0] REG_ALS_H      = 6'h03;
    localparam logic [5:0] REG_ALS_L      = 6'h04;
    localparam logic [5:0] REG_IRQ_ENABLE = 6'h05;
    localparam logic [5:0] REG_COMMAND    = 6'h06;
    localparam logic [5:0] REG_PARAM_IN   = 6'h07;
    localparam logic [5:0] REG_RESPONSE1  = 6'h08;
    localparam logic [5:0] REG_CMD_RESP   = 6'h09;
    localparam logic [5:0] REG_DEV_ADDR   = 6'h0A;

    // Interrupt status bit positions
    localparam int IRQ_PS_DONE  = 0;
    localparam int IRQ_ALS_DONE = 1;
    localparam int IRQ_PS_THR   = 2;
    localparam int IRQ_ALS_THR  = 3;

    // Command codes
    localparam logic [7:0] CMD_COUNTER_CLEAR = 8'h00;
    localparam logic [7:0] CMD_SOFT_RESET    = 8'h01;
    localparam logic [7:0] CMD_FORCE         = 8'h11;
    localparam logic [7:0] CMD_PAUSE         = 8'h12;
    localparam logic [7:0] CMD_START         = 8'h13;
    localparam logic [1:0] CMD_PARAM_READ    = 2'h1;
    localparam logic [1:0] CMD_PARAM_WRITE   = 2'h2;

    // Parameter table layout
    localparam int         PARAM_DEPTH    = 8'h2C;
    localparam logic [5:0] PAR_CHAN_LIST  = 6'h01;
    localparam logic [5:0] PAR_RATE_H     = 6'h1A;
    localparam logic [5:0] PAR_RATE_L     = 6'h1B;
    localparam logic [5:0] PAR_PS_THR_H   = 6'h25;
    localparam logic [5:0] PAR_PS_THR_L   = 6'h26;
    localparam logic [5:0] PAR_ALS_THR_H  = 6'h27;
    localparam logic [5:0] PAR_ALS_THR_L  = 6'h28;
    localparam int         CHAN_PS_BIT    = 0;
    localparam int         CHAN_ALS_BIT   = 1;

    // Reset values
    localparam logic [3:0] CMD_COUNT_RESET = 4'hF;
    localparam logic [7:0] PARAM_RESET     = 8'h00;

endpackage

// ===== testbench/smp_host_side.sv
// Host side model: pulled-up shared interrupt line and address strap resistor
`timescale 1ns/1ps
`default_nettype none
module smp_host_side (
    input  wire logic int_o,
    input  wire logic int_oe,
    input  wire logic strap_up,
    output logic      int_line,
    output logic      strap_pin
);
    // Pull-up wins unless the device pulls the shared line
    assign int_line = int_oe ? int_o : 1'b1;
    assign strap_pin = strap_up;
endmodule
`default_nettype wire

// ===== testbench/smp_mode_ctrl_assertions.sv
// Port-level checker for the sensor mode controller
`timescale 1ns/1ps
`default_nettype none
module smp_mode_ctrl_chk (
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic        SECOND_EMITTER_DRIVE_PIN,
    input wire logic        HOST_WR,
    input wire logic        HOST_RD,
    input wire logic [5:0]  HOST_ADDR,
    input wire logic [7:0]  HOST_WDATA,
    input wire logic [7:0]  HOST_RDATA,
    input wire logic        BUS_ADDR_VALID,
    input wire logic [6:0]  BUS_ADDR,
    input wire logic        BUS_ADDR_TEN,
    input wire logic        BUS_ADDR_ACK,
    input wire logic [15:0] PS_SAMPLE,
    input wire logic [15:0] ALS_SAMPLE,
    input wire logic        MEAS_ACTIVE,
    input wire logic [2:0]  MODE,
    input wire logic        INT_O,
    input wire logic        INT_OE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    logic [10:0] init_cnt;
    // Saturating, so a stuck init state still trips the bound
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            init_cnt <= 11'h000;
        end else if (MODE != smp_pkg::MODE_INIT) begin
            init_cnt <= 11'h000;
        end else if (init_cnt != 11'h7FF) begin
            init_cnt <= init_cnt + 11'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_cmd(logic [7:0] c);
        HOST_WR && HOST_ADDR == smp_pkg::REG_COMMAND && HOST_WDATA == c;
    endsequence
    sequence s_init_done;
        (MODE == smp_pkg::MODE_INIT) ##1 (MODE != smp_pkg::MODE_INIT);
    endsequence
    property p_init_end;
        s_init_done |-> MODE == smp_pkg::MODE_STANDBY;
    endproperty
    property p_init_len;
        MODE == smp_pkg::MODE_INIT |-> init_cnt < 11'h3E8;
    endproperty
    property p_soft;
        s_cmd(smp_pkg::CMD_SOFT_RESET) ##0 (MODE >= smp_pkg::MODE_STANDBY)
            |-> ##[1:2] MODE == smp_pkg::MODE_INIT;
    endproperty
    property p_force;
        (MODE == smp_pkg::MODE_STANDBY) ##0 s_cmd(smp_pkg::CMD_FORCE)
            |=> MODE == smp_pkg::MODE_FORCED && MEAS_ACTIVE;
    endproperty
    property p_forced_done;
        (MODE == smp_pkg::MODE_FORCED && MEAS_ACTIVE && !HOST_WR) ##1 !MEAS_ACTIVE
            |-> MODE == smp_pkg::MODE_STANDBY;
    endproperty
    property p_standby_idle;
        MODE == smp_pkg::MODE_STANDBY |-> !MEAS_ACTIVE;
    endproperty
    property p_rd_sleep;
        HOST_RD && !HOST_WR && MODE == smp_pkg::MODE_STANDBY |=> MODE == smp_pkg::MODE_STANDBY;
    endproperty
    property p_int_hold;
        INT_OE && !HOST_WR |=> INT_OE;
    endproperty
    property p_int_cause;
        $rose(INT_OE) |-> $fell(MEAS_ACTIVE)
            || ($past(HOST_WR) && $past(HOST_ADDR) == smp_pkg::REG_IRQ_ENABLE);
    endproperty
    property p_ack_ten;
        BUS_ADDR_TEN |-> !BUS_ADDR_ACK;
    endproperty
    property p_ack_src;
        BUS_ADDR_ACK |-> BUS_ADDR_VALID && MODE >= smp_pkg::MODE_STANDBY;
    endproperty
    a_init_end: assert property (p_init_end) else $error("init did not end in standby");
    a_init_len: assert property (p_init_len) else $error("init runs too long");
    a_soft: assert property (p_soft) else $error("soft reset missed init");
    a_force: assert property (p_force) else $error("force did not start");
    a_forced_done: assert property (p_forced_done) else $error("forced end not standby");
    a_standby_idle: assert property (p_standby_idle) else $error("measuring in standby");
    a_rd_sleep: assert property (p_rd_sleep) else $error("read left standby");
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped alone");
    a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
    a_ack_ten: assert property (p_ack_ten) else $error("ten-bit header acked");
    a_ack_src: assert property (p_ack_src) else $error("ack without address");
endmodule
bind smp_mode_ctrl smp_mode_ctrl_chk smp_mode_ctrl_chk_i (.*);
`default_nettype wire

// ===== testbench/test_sensor_mode_and_host_mailbox_ctrl.sv
// Self-checking bench for the sensor mode controller
`timescale 1ns/1ps
`default_nettype none
module test_sensor_mode_and_host_mailbox_ctrl;
    logic clk_sys, rstn, strap_up, strap_pin, host_wr, host_rd;
    logic bus_valid, bus_ten, bus_ack, meas, int_o, int_oe, int_line;
    logic [5:0]  host_addr, a;
    logic [7:0]  host_wdata, host_rdata, d;
    logic [6:0]  bus_addr;
    logic [15:0] ps, als;
    logic [2:0]  mode;
    logic [3:0]  cnt;
    int          errors, compares, cycles, seed, n;
    smp_mode_ctrl smp_mode_ctrl_i (.CLK_SYS(clk_sys), .RSTN(rstn),
        .SECOND_EMITTER_DRIVE_PIN(strap_pin), .HOST_WR(host_wr), .HOST_RD(host_rd),
        .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
        .BUS_ADDR_VALID(bus_valid), .BUS_ADDR(bus_addr), .BUS_ADDR_TEN(bus_ten),
        .BUS_ADDR_ACK(bus_ack), .PS_SAMPLE(ps), .ALS_SAMPLE(als), .MEAS_ACTIVE(meas),
        .MODE(mode), .INT_O(int_o), .INT_OE(int_oe));
    smp_host_side smp_host_side_i (.int_o(int_o), .int_oe(int_oe), .strap_up(strap_up),
        .int_line(int_line), .strap_pin(strap_pin));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] resp0(input logic err, input logic [3:0] c);
        return {3'h0, err, c};
    endfunction
    function automatic logic [6:0] addr_of(input logic s);
        return s ? smp_pkg::ADDR_PRIMARY : smp_pkg::ADDR_ALTERNATE;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
        @(posedge clk_sys);
        host_wr <= 1'b1;
        host_addr <= ad;
        host_wdata <= dt;
        @(posedge clk_sys);
        host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ad, input logic [7:0] exp);
        @(posedge clk_sys);
        host_rd <= 1'b1;
        host_addr <= ad;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        @(posedge clk_sys);
        #1 chk(host_rdata, exp);
    endtask
    task automatic pwr(input logic [5:0] ad, input logic [7:0] dt);
        wr(smp_pkg::REG_PARAM_IN, dt);
        wr(smp_pkg::REG_COMMAND, {2'h2, ad});
        cnt++;
    endtask
    task automatic pq(input logic [5:0] ad);
        wr(smp_pkg::REG_COMMAND, {2'h1, ad});
    endtask
    task automatic ack(input logic [6:0] ad, input logic ten, input logic exp);
        @(posedge clk_sys);
        bus_valid <= 1'b1;
        bus_addr <= ad;
        bus_ten <= ten;
        #1 chk({7'h00, bus_ack}, {7'h00, exp});
        @(posedge clk_sys);
        bus_valid <= 1'b0;
    endtask
    // Bounded wait, landing edge updates before the first look
    task automatic wait_mode(input logic [2:0] m);
        #1 n = 0;
        while (mode !== m && n < 8000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk({5'h00, mode}, {5'h00, m});
    endtask
    task automatic summarize;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {errors, compares, cycles} = '0;
        {rstn, host_wr, host_rd, bus_valid, bus_ten} = '0;
        {host_addr, host_wdata, bus_addr, ps, als} = '0;
        strap_up = 1'b1;
        seed = $urandom(97);
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_mode(smp_pkg::MODE_STANDBY);
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b0, 4'hF));
        rd(smp_pkg::REG_DEV_ADDR, {1'b0, addr_of(1'b1)});
        ack(addr_of(1'b1), 1'b0, 1'b1);
        ack(addr_of(1'b0), 1'b0, 1'b0);
        ack(addr_of(1'b1), 1'b1, 1'b0);
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_COUNTER_CLEAR);
        cnt = 4'h0;
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 6'h2B : 6'($urandom % 44);
            d = 8'($urandom);
            pwr(a, d);
            rd(smp_pkg::REG_RESPONSE1, d);
            pq(a);
            cnt++;
            rd(smp_pkg::REG_RESPONSE1, d);
            rd(smp_pkg::REG_CMD_RESP, resp0(1'b0, cnt));
        end
        pq(6'h2C);
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b1, cnt));
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_COUNTER_CLEAR);
        cnt = 4'h0;
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b0, cnt));
        // Unknown code flags an error and freezes the count
        wr(smp_pkg::REG_COMMAND, 8'hFF);
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b1, cnt));
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_COUNTER_CLEAR);
        // Rate set before start; zero thresholds are always reached
        pwr(smp_pkg::PAR_CHAN_LIST, 8'h03);
        for (int t = 37; t < 41; t++) pwr(6'(t), 8'h00);
        pwr(smp_pkg::PAR_RATE_H, 8'h00);
        pwr(smp_pkg::PAR_RATE_L, 8'h01);
        wr(smp_pkg::REG_IRQ_ENABLE, 8'h0F);
        ps <= 16'($urandom);
        als <= 16'($urandom);
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_FORCE);
        cnt++;
        wait_mode(smp_pkg::MODE_FORCED);
        wait_mode(smp_pkg::MODE_STANDBY);
        chk({7'h00, int_line}, 8'h00);
        rd(smp_pkg::REG_IRQ_STATUS, 8'h0F);
        rd(smp_pkg::REG_PS_H, ps[15:8]);
        rd(smp_pkg::REG_PS_L, ps[7:0]);
        rd(smp_pkg::REG_ALS_H, als[15:8]);
        rd(smp_pkg::REG_ALS_L, als[7:0]);
        chk({7'h00, int_line}, 8'h00);
        // Enable gates the line while status stays pending
        wr(smp_pkg::REG_IRQ_ENABLE, 8'h00);
        #1 chk({7'h00, int_line}, 8'h01);
        wr(smp_pkg::REG_IRQ_ENABLE, 8'h0F);
        #1 chk({7'h00, int_line}, 8'h00);
        wr(smp_pkg::REG_IRQ_STATUS, 8'h0F);
        ps <= 16'($urandom);
        #1 chk({7'h00, int_line}, 8'h01);
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_START);
        wait_mode(smp_pkg::MODE_AUTO);
        n = 0;
        while (int_line !== 1'b0 && n < 8000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk({7'h00, int_line}, 8'h00);
        rd(smp_pkg::REG_PS_L, ps[7:0]);
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_PAUSE);
        cnt = cnt + 4'h2;
        wait_mode(smp_pkg::MODE_STANDBY);
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b0, cnt));
        wr(smp_pkg::REG_DEV_ADDR, 8'h21);
        ack(7'h21, 1'b0, 1'b1);
        strap_up <= 1'b0;
        wr(smp_pkg::REG_COMMAND, smp_pkg::CMD_SOFT_RESET);
        ack(addr_of(1'b0), 1'b0, 1'b0);
        wait_mode(smp_pkg::MODE_STANDBY);
        ack(addr_of(1'b0), 1'b0, 1'b1);
        ack(7'h21, 1'b0, 1'b0);
        rd(smp_pkg::REG_CMD_RESP, resp0(1'b0, 4'hF));
        pq(smp_pkg::PAR_CHAN_LIST);
        rd(smp_pkg::REG_RESPONSE1, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
